// File: src/wcp_regs.sv
// module: channel 7 window comparator registers and channel 0/1 peak trackers
`timescale 1ns/10ps
`default_nettype none
module wcp_regs (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // register port from the serial engine
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // conversion results
  input  wire logic        conv_valid,
  input  wire logic [2:0]  conv_chan,
  input  wire logic [11:0] conv_code,
  // channel 7 monitor
  output logic             ch7_event_set,
  output logic             ch7_high_alarm,
  output logic             ch7_low_alarm
);
  //==========================================================================
  // declarations
  logic [7:0]  hyst_nib_reg;
  logic [7:0]  upper_reg;
  logic [7:0]  deb_nib_reg;
  logic [7:0]  lower_reg;
  logic [3:0]  run_cnt_reg;
  logic [3:0]  run_cnt_next;
  logic        event_next;
  logic        high_next;
  logic        low_next;
  logic [7:0]  rdata_next;
  wire  [11:0] upper_limit;
  wire  [11:0] lower_limit;
  wire  [6:0]  hyst_amt;
  wire  [12:0] upper_rel;
  wire  [12:0] lower_rel;
  wire  [3:0]  debounce_sample_count;
  wire         win_sample;
  wire         over_high;
  wire         under_low;
  wire         out_win;
  wire         wr_hyst;
  wire         wr_upper;
  wire         wr_deb;
  wire         wr_lower;
  wire [11:0]  peak_val [wcp_pkg::PEAK_CHANS];
  wire         sel_hyst;
  wire         sel_upper;
  wire         sel_deb;
  wire         sel_lower;
  wire         sel_pk0lo;
  wire         sel_pk0hi;
  wire         sel_pk1lo;
  wire         sel_pk1hi;
  wire         sel_none;

  //==========================================================================
  // elaboration checks: ports and the read mux are sized for two trackers
  // of 12-bit codes; other package values are refused here
  if (wcp_pkg::PEAK_CHANS != 2) begin : g_chk_chans
    $error("wcp_regs serves exactly two peak trackers");
  end
  if (wcp_pkg::CODE_W != 12) begin : g_chk_code
    $error("wcp_regs result code must be 12 bits wide");
  end
  if (wcp_pkg::NIB_W + wcp_pkg::HYST_SH != wcp_pkg::HYST_W) begin : g_hw
    $error("hysteresis width must be field width plus shift");
  end

  //==========================================================================
  // limit assembly: top byte against result 11:4, nibble against 3:0
  // low nibbles of the two nibble registers carry the hysteresis and count
  assign upper_limit = {upper_reg,
                        hyst_nib_reg[7:wcp_pkg::NIB_HI_LSB]};
  assign lower_limit = {lower_reg,
                        deb_nib_reg[7:wcp_pkg::NIB_HI_LSB]};
  assign hyst_amt    = {hyst_nib_reg[3:wcp_pkg::NIB_LO_LSB], 3'h0};
  assign debounce_sample_count = deb_nib_reg[3:wcp_pkg::NIB_LO_LSB];

  // release points move inward by the hysteresis while an alarm stands
  // an underflow of the upper release point keeps the alarm standing
  assign upper_rel = {1'b0, upper_limit} - {6'h00, hyst_amt};
  assign lower_rel = {1'b0, lower_limit} + {6'h00, hyst_amt};

  //==========================================================================
  // window test on channel 7 samples
  // while an alarm stands the test moves to the release point, so a code
  // hovering at the limit does not make the alarm chatter
  assign win_sample = conv_valid && (conv_chan == wcp_pkg::WIN_CHAN);
  assign over_high  = ch7_high_alarm ?
                      (upper_rel[12] || ({1'b0, conv_code} > upper_rel)) :
                      (conv_code > upper_limit);
  assign under_low  = ch7_low_alarm ?
                      ({1'b0, conv_code} < lower_rel) :
                      (conv_code < lower_limit);
  assign out_win    = over_high || under_low;

  // consecutive out-of-window run and event decision
  // the run holds at n, so each further out sample pulses again
  always_comb begin
    run_cnt_next = run_cnt_reg;
    event_next   = 1'b0;
    high_next    = ch7_high_alarm;
    low_next     = ch7_low_alarm;
    if (win_sample) begin
      high_next = over_high;
      low_next  = under_low;
      if (!out_win) begin
        run_cnt_next = 4'h0;
      end else if (run_cnt_reg >= debounce_sample_count) begin
        event_next = 1'b1;
      end else begin
        run_cnt_next = run_cnt_reg + 4'h1;
      end
    end
  end

  //==========================================================================
  // write decode
  // peak and unmapped offsets have no write select: such writes fall away
  assign wr_hyst  = reg_wr && (reg_addr == wcp_pkg::OFS_CH7_HYST_NIB);
  assign wr_upper = reg_wr && (reg_addr == wcp_pkg::OFS_CH7_UPPER);
  assign wr_deb   = reg_wr && (reg_addr == wcp_pkg::OFS_CH7_DEB_NIB);
  assign wr_lower = reg_wr && (reg_addr == wcp_pkg::OFS_CH7_LOWER);

  // configuration registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hyst_nib_reg <= wcp_pkg::RST_CH7_HYST_NIB;
      upper_reg    <= wcp_pkg::RST_CH7_UPPER;
      deb_nib_reg  <= wcp_pkg::RST_CH7_DEB_NIB;
      lower_reg    <= wcp_pkg::RST_CH7_LOWER;
    end else begin
      if (wr_hyst)  hyst_nib_reg <= reg_wdata;
      if (wr_upper) upper_reg    <= reg_wdata;
      if (wr_deb)   deb_nib_reg  <= reg_wdata;
      if (wr_lower) lower_reg    <= reg_wdata;
    end
  end

  // monitor state
  // event is a one-cycle pulse; alarms stand until the next channel 7 sample
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_cnt_reg    <= 4'h0;
      ch7_event_set  <= 1'b0;
      ch7_high_alarm <= 1'b0;
      ch7_low_alarm  <= 1'b0;
    end else begin
      run_cnt_reg    <= run_cnt_next;
      ch7_event_set  <= event_next;
      ch7_high_alarm <= high_next;
      ch7_low_alarm  <= low_next;
    end
  end

  //==========================================================================
  // peak trackers for channels 0 and 1
  // a read clears only its own byte, so a host reading low then high may
  // see a torn code if a larger sample lands between the two reads
  genvar gi;
  generate
    for (gi = 0; gi < wcp_pkg::PEAK_CHANS; gi++) begin : g_peak
      wcp_peak_if pk_if ();
      wire [7:0] lo_ofs;
      wire [7:0] hi_ofs;
      // byte offsets of this tracker's read-clear registers
      assign lo_ofs = wcp_pkg::OFS_PEAK0_LO + 8'(2 * gi);
      assign hi_ofs = wcp_pkg::OFS_PEAK0_HI + 8'(2 * gi);
      assign pk_if.sample_valid = conv_valid &&
                                  (conv_chan == 3'(gi));
      assign pk_if.sample_code  = conv_code;
      assign pk_if.clr_lo = reg_rd && (reg_addr == lo_ofs);
      assign pk_if.clr_hi = reg_rd && (reg_addr == hi_ofs);
      assign peak_val[gi] = pk_if.peak;
      wcp_peak u_peak (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .pk      (pk_if.trk)
      );
    end
  endgenerate

  //==========================================================================
  // read selects, one per mapped offset
  assign sel_hyst  = (reg_addr == wcp_pkg::OFS_CH7_HYST_NIB);
  assign sel_upper = (reg_addr == wcp_pkg::OFS_CH7_UPPER);
  assign sel_deb   = (reg_addr == wcp_pkg::OFS_CH7_DEB_NIB);
  assign sel_lower = (reg_addr == wcp_pkg::OFS_CH7_LOWER);
  assign sel_pk0lo = (reg_addr == wcp_pkg::OFS_PEAK0_LO);
  assign sel_pk0hi = (reg_addr == wcp_pkg::OFS_PEAK0_HI);
  assign sel_pk1lo = (reg_addr == wcp_pkg::OFS_PEAK1_LO);
  assign sel_pk1hi = (reg_addr == wcp_pkg::OFS_PEAK1_HI);
  // no select high means an unmapped offset, which answers zero
  assign sel_none  = !(sel_hyst  || sel_upper || sel_deb   || sel_lower ||
                       sel_pk0lo || sel_pk0hi || sel_pk1lo || sel_pk1hi);

  // and-or read mux; peak high bytes read zero in bits 7:4
  assign rdata_next = ({8{sel_hyst}}  & hyst_nib_reg)
                    | ({8{sel_upper}} & upper_reg)
                    | ({8{sel_deb}}   & deb_nib_reg)
                    | ({8{sel_lower}} & lower_reg)
                    | ({8{sel_pk0lo}} & peak_val[0][7:0])
                    | ({8{sel_pk0hi}} & {4'h0, peak_val[0][11:8]})
                    | ({8{sel_pk1lo}} & peak_val[1][7:0])
                    | ({8{sel_pk1hi}} & {4'h0, peak_val[1][11:8]})
                    | ({8{sel_none}}  & wcp_pkg::RD_UNMAPPED);

  // read data captured on the read strobe, held until the next read
  // the host's view stays still between reads, even while peaks move
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end
endmodule // wcp_regs
`default_nettype wire

// File: src/wcp_pkg.sv
// package: register map, resets and field layout of the window and peak slice
//==========================================================================
// Behaviour
// - upper-limit top byte, reset all ones, compared with result bits 11:4.
// - upper-limit low nibble in hysteresis reg bits 7:4, reset 1111b, vs 3:0.
// - hysteresis is field shifted left three, subtracted from or added to the whole 12-bit limit.
// - lower-limit low nibble in debounce reg bits 7:4, reset 0, vs bits 3:0.
// - lower-limit top byte in own register, reset 0, vs result bits 11:4.
// - event raised only after n+1 consecutive out-of-window samples, n resets 0.
// - channels 0 and 1 keep highest code since last read, as low/high bytes.
// - reading a peak byte register clears it to zero.
package wcp_pkg;
  //==========================================================================
  // widths
  localparam int unsigned CODE_W  = 12;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned CHAN_W  = 3;
  localparam int unsigned NIB_W   = 4;
  localparam int unsigned HYST_W  = 7;
  localparam int unsigned HYST_SH = 3;

  //==========================================================================
  // register offsets
  localparam logic [7:0] OFS_CH7_HYST_NIB = 8'h3c;
  localparam logic [7:0] OFS_CH7_UPPER    = 8'h3d;
  localparam logic [7:0] OFS_CH7_DEB_NIB  = 8'h3e;
  localparam logic [7:0] OFS_CH7_LOWER    = 8'h3f;
  localparam logic [7:0] OFS_PEAK0_LO     = 8'h60;
  localparam logic [7:0] OFS_PEAK0_HI     = 8'h61;
  localparam logic [7:0] OFS_PEAK1_LO     = 8'h62;
  localparam logic [7:0] OFS_PEAK1_HI     = 8'h63;

  //==========================================================================
  // reset values
  localparam logic [7:0] RST_CH7_HYST_NIB = 8'hf0;
  localparam logic [7:0] RST_CH7_UPPER    = 8'hff;
  localparam logic [7:0] RST_CH7_DEB_NIB  = 8'h00;
  localparam logic [7:0] RST_CH7_LOWER    = 8'h00;
  localparam logic [7:0] RST_PEAK         = 8'h00;
  localparam logic [7:0] RD_UNMAPPED      = 8'h00;

  //==========================================================================
  // field positions and channel numbers
  localparam int unsigned NIB_HI_LSB = 4;
  localparam int unsigned NIB_LO_LSB = 0;
  localparam logic [2:0]  WIN_CHAN   = 3'h7;
  localparam int unsigned PEAK_CHANS = 2;
endpackage

// File: src/wcp_peak_if.sv
// interface: conversion feed and read-clear strobes for one peak tracker
`timescale 1ns/10ps
`default_nettype none
interface wcp_peak_if;
  logic                        sample_valid;
  logic [wcp_pkg::CODE_W-1:0]  sample_code;
  logic                        clr_lo;
  logic                        clr_hi;
  logic [wcp_pkg::CODE_W-1:0]  peak;

  modport regs (output sample_valid, output sample_code,
                output clr_lo, output clr_hi, input peak);
  modport trk  (input sample_valid, input sample_code,
                input clr_lo, input clr_hi, output peak);
endinterface
`default_nettype wire

// File: src/wcp_peak.sv
// module: highest-code tracker for one channel with per-byte read clear
`timescale 1ns/10ps
`default_nettype none
module wcp_peak (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // feed from the register bank
  wcp_peak_if.trk   pk
);
  logic [wcp_pkg::CODE_W-1:0] peak_reg;
  logic [wcp_pkg::CODE_W-1:0] peak_next;
  wire                        bigger;

  //==========================================================================
  // next value: a larger sample wins over a clear in the same cycle
  assign bigger = pk.sample_valid && (pk.sample_code > peak_reg);
  always_comb begin
    peak_next = peak_reg;
    if (pk.clr_lo) begin
      peak_next[7:0] = wcp_pkg::RST_PEAK;
    end
    if (pk.clr_hi) begin
      peak_next[wcp_pkg::CODE_W-1:8] = wcp_pkg::RST_PEAK[3:0];
    end
    if (bigger) begin
      peak_next = pk.sample_code;
    end
  end

  // peak store
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      peak_reg <= '0;
    end else begin
      peak_reg <= peak_next;
    end
  end

  assign pk.peak = peak_reg;
endmodule // wcp_peak
`default_nettype wire

// File: tb/wcp_regs_assertions.sv
// checker: port-level properties of the window and peak register slice
`timescale 1ns/10ps
`default_nettype none
module wcp_regs_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // conversions and monitor
  input wire logic        conv_valid,
  input wire logic [2:0]  conv_chan,
  input wire logic [11:0] conv_code,
  input wire logic        ch7_event_set,
  input wire logic        ch7_high_alarm,
  input wire logic        ch7_low_alarm
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  //==========================================================================
  // steps of a read-clear and of a write-then-read
  sequence s_pk_rd;
    reg_rd && reg_addr[7:2] == 6'h18 && !conv_valid;
  endsequence
  sequence s_cfg_wr;
    reg_wr && reg_addr[7:2] == 6'h0f;
  endsequence
  //==========================================================================
  // properties
  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr[7:2] != 6'h0f && reg_addr[7:2] != 6'h18
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_peak_clear: assert property (
    s_pk_rd ##1 !conv_valid ##1 (reg_rd && reg_addr == $past(reg_addr, 2))
    |=> reg_rdata == 8'h00) else $error("peak byte not cleared by read");
  a_cfg_readback: assert property (
    s_cfg_wr ##1 !reg_wr ##1 (reg_rd && reg_addr == $past(reg_addr, 2))
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("config readback");
  a_hi_nib_zero: assert property (
    reg_rd && (reg_addr == 8'h61 || reg_addr == 8'h63)
    |=> reg_rdata[7:4] == 4'h0) else $error("peak high nibble not zero");
  a_event_cause: assert property (
    ch7_event_set |-> $past(conv_valid) && $past(conv_chan) == 3'h7)
    else $error("event without channel 7 sample");
  a_alarm_steady: assert property (
    !conv_valid || conv_chan != 3'h7 |=> $stable(ch7_high_alarm)
    && $stable(ch7_low_alarm) && !ch7_event_set) else $error("idle change");
  a_event_alarm: assert property (
    ch7_event_set |-> ch7_high_alarm || ch7_low_alarm)
    else $error("event with sample inside window");
endmodule // wcp_regs_chk
`default_nettype wire

// File: tb/wcp_conv_src.sv
// partner: conversion engine handing results to the register slice
`timescale 1ns/10ps
`default_nettype none
module wcp_conv_src (
  // clock
  input  wire logic  sys_clk,
  // result feed
  output logic       conv_valid,
  output logic [2:0] conv_chan,
  output logic [11:0] conv_code
);
  // idle feed
  initial begin
    conv_valid = 1'b0;
    conv_chan = 3'h0;
    conv_code = 12'h000;
  end
  // cnt back-to-back results; stale fields inverted once valid drops
  task automatic send(input logic [2:0] ch, input logic [11:0] cd,
                      input int cnt);
    @(posedge sys_clk);
    conv_valid <= 1'b1;
    conv_chan <= ch;
    conv_code <= cd;
    repeat (cnt) @(posedge sys_clk);
    conv_valid <= 1'b0;
    conv_chan <= ~ch;
    conv_code <= ~cd;
  endtask
endmodule // wcp_conv_src
`default_nettype wire

// File: tb/window_compare_and_peak_regs_tb.sv
// testbench: register access, window monitor and peak trackers
`timescale 1ns/10ps
`default_nettype none
module window_compare_and_peak_regs_tb;
  logic        sys_clk, rst_b, reg_wr, reg_rd, conv_valid;
  logic        ev, hi, lo;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [2:0]  conv_chan;
  logic [11:0] conv_code;
  int          n_fail, comparisons;
  logic [7:0]  ra [9] = '{8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h60, 8'h61, 8'h62,
                          8'h63, 8'h40};
  logic [7:0]  rv [9] = '{8'hf0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                          8'h00, 8'h00};
  // clock and instances
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;
  wcp_regs uut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_valid(conv_valid), .conv_chan(conv_chan),
    .conv_code(conv_code), .ch7_event_set(ev), .ch7_high_alarm(hi),
    .ch7_low_alarm(lo));
  wcp_conv_src pm (.sys_clk(sys_clk), .conv_valid(conv_valid),
    .conv_chan(conv_chan), .conv_code(conv_code));
  // compare, access and verdict tasks
  task automatic chk(input string nm, input logic [11:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("read data", {4'h0, e}, {4'h0, reg_rdata});
  endtask
  task automatic mon(input logic e, h, l);
    #1 chk("monitor", {9'h0, e, h, l}, {9'h0, ev, hi, lo});
  endtask
  task automatic end_sim;
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // bound on run length
  initial begin
    repeat (3000) @(posedge sys_clk);
    chk("run length", 12'h000, 12'h001);
    end_sim;
  end
  // main sequence
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(ra[i], rv[i]);
    end
    wr(8'h3d, 8'h80);
    rd(8'h3d, 8'h80);
    wr(8'h3c, 8'h50);
    rd(8'h3c, 8'h50);
    wr(8'h3e, 8'h31);
    rd(8'h3e, 8'h31);
    wr(8'h3f, 8'h10);
    rd(8'h3f, 8'h10);
    pm.send(3'h7, 12'h805, 2);
    mon(1'b0, 1'b0, 1'b0);
    pm.send(3'h7, 12'h806, 2);
    mon(1'b1, 1'b1, 1'b0);
    pm.send(3'h7, 12'h200, 1);
    pm.send(3'h7, 12'h806, 1);
    mon(1'b0, 1'b1, 1'b0);
    wr(8'h3c, 8'h51);
    pm.send(3'h7, 12'h806, 2);
    mon(1'b1, 1'b1, 1'b0);
    pm.send(3'h7, 12'h7fe, 1);
    mon(1'b1, 1'b1, 1'b0);
    pm.send(3'h7, 12'h7fd, 1);
    mon(1'b0, 1'b0, 1'b0);
    pm.send(3'h7, 12'h102, 2);
    mon(1'b1, 1'b0, 1'b1);
    pm.send(3'h7, 12'h10a, 1);
    mon(1'b1, 1'b0, 1'b1);
    pm.send(3'h7, 12'h10b, 1);
    mon(1'b0, 1'b0, 1'b0);
    pm.send(3'h0, 12'habc, 1);
    pm.send(3'h0, 12'h123, 1);
    pm.send(3'h1, 12'h5a5, 1);
    rd(8'h60, 8'hbc);
    rd(8'h60, 8'h00);
    rd(8'h61, 8'h0a);
    rd(8'h61, 8'h00);
    wr(8'h62, 8'hff);
    rd(8'h62, 8'ha5);
    rd(8'h62, 8'h00);
    rd(8'h63, 8'h05);
    pm.send(3'h0, 12'h011, 1);
    rd(8'h60, 8'h11);
    end_sim;
  end
endmodule // window_compare_and_peak_regs_tb
bind wcp_regs wcp_regs_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_valid(conv_valid),
  .conv_chan(conv_chan), .conv_code(conv_code),
  .ch7_event_set(ch7_event_set), .ch7_high_alarm(ch7_high_alarm),
  .ch7_low_alarm(ch7_low_alarm));
`default_nettype wire
